/* File: common/cmr_pkg.sv */
`default_nettype none
package cmr_pkg;

  // stream framing
  localparam int DUMMY_BITS = 5;
  localparam int CHECK_BITS = 4;
  localparam int FIRST_HIGH_BITS = 2;
  localparam int LAST_HIGH_BITS = 7;
  localparam int CRC_W = 11;
  localparam int LOAD_WINDOW = 6;

  // capture layout per frame: four logic_cell outputs, two io_cell output
  // flip-flops, io_input_first, io_input_second
  localparam int CAP_W = 8;

  // reset values, start level and fill level
  localparam logic [CRC_W-1:0] CRC_INIT = 11'h7ff;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic FILL_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    CMR_IDLE = 3'b000,
    CMR_DUMMY = 3'b001,
    CMR_START = 3'b010,
    CMR_DATA = 3'b011,
    CMR_CHECK = 3'b100,
    CMR_LSTART = 3'b101,
    CMR_CRC = 3'b110,
    CMR_END = 3'b111
  } cmr_state_t;

  // one serial step of the signature register, msb first
  function automatic logic [CRC_W-1:0] cmr_crc_step(
    input logic [CRC_W-1:0] crc,
    input logic bit_in,
    input logic [CRC_W-1:0] poly
  );
    logic fb;
    fb = crc[CRC_W-1] ^ bit_in;
    return {crc[CRC_W-2:0], 1'b0} ^ (fb ? poly : {CRC_W{1'b0}});
  endfunction

endpackage
`default_nettype wire

/* File: rtl/cmr_config_memory_readback.sv */
// Operation
// R1: readback runs beside normal user logic undisturbed
// R2: trigger high raises in-progress on next edge; here rip rises on the third edge, after the trigger sync
// R3: each later edge presents next stream bit
// R4: no preamble in the stream
// R5: five high dummies, then low start
// R6: first two data bits of frame one high
// R7: four high check bits close each frame
// R8: last seven bits of last frame high
// R9: final start, 11-bit signature, then in-progress low
// R10: configuration bits returned without inversion
// R11: capture samples inverted cell outputs on trigger rise
// R12: without capture, positions keep loaded configuration
// R13: user RAM writes show in function-table positions
// R14: abort: trigger fall ends readback, re-arms
// R15: controller gives extra clocks after abort
// R16: config clock default, user clock selectable, rising
// R17: options fixed at elaboration, never change
// R18: next frame loaded in last six cycles
// R19: controller keeps clock timing near start bits
// R20: controller tracks position, no pause near boundaries
// R21: unconnected control nets make readback impossible
// R22: three config clocks after done before readback
// R23: restart needs trigger low then high again
`timescale 1ns/1ps
`default_nettype none
module cmr_config_memory_readback
  import cmr_pkg::*;
#(
  parameter int FRAMES = 8,
  parameter int FRAME_BITS = 32,
  parameter int CAP_POS = 8,
  parameter bit CAPTURE_EN = 1'b1,
  parameter bit ABORT_EN = 1'b1,
  parameter bit USE_USER_CLOCK = 1'b0,
  parameter logic [10:0] CRC_POLY = 11'h305
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic config_clock,
  input wire logic readback_shift_clock,
  input wire logic config_done,
  input wire logic readback_trigger,
  input wire logic cfg_wr_en,
  input wire logic [$clog2(FRAMES)-1:0] cfg_wr_frame,
  input wire logic [FRAME_BITS-1:0] cfg_wr_data,
  input wire logic ram_wr_en,
  input wire logic [$clog2(FRAMES)-1:0] ram_wr_frame,
  input wire logic [$clog2(FRAME_BITS)-1:0] ram_wr_bit,
  input wire logic ram_wr_value,
  input wire logic [FRAMES*CAP_W-1:0] capture_nodes,
  output logic read_in_progress,
  output logic readback_serial_out
);

  localparam int FW = $clog2(FRAMES);
  localparam int CW = $clog2(FRAME_BITS + CHECK_BITS + 1);
  localparam logic [FW-1:0] LAST_FRAME = FW'(FRAMES - 1);
  localparam logic [CW-1:0] DUMMY_LAST = CW'(DUMMY_BITS - 1);
  localparam logic [CW-1:0] DATA_LAST = CW'(FRAME_BITS - 1);
  localparam logic [CW-1:0] CHECK_LAST = CW'(CHECK_BITS - 1);
  localparam logic [CW-1:0] FIRST_HIGH_END = CW'(FIRST_HIGH_BITS);
  localparam logic [CW-1:0] LAST_HIGH_START = CW'(FRAME_BITS + CHECK_BITS - LAST_HIGH_BITS);
  // the request goes out when the window of LOAD_WINDOW edges before a start bit opens
  localparam logic [CW-1:0] REQ_POS = CW'(FRAME_BITS + CHECK_BITS - (LOAD_WINDOW - 1));
  localparam logic [CW-1:0] CRC_LAST = CW'(CRC_W - 1);

  generate
    if (FRAMES < 2 || FRAME_BITS < CAP_POS + CAP_W || FRAME_BITS + CHECK_BITS < LAST_HIGH_BITS ||
        FRAME_BITS + CHECK_BITS < LOAD_WINDOW) begin : g_bad_params
      $error("cmr_config_memory_readback: unsupported frame geometry");
    end
  endgenerate

  // option is fixed at elaboration, so this is a constant select, not a live clock mux
  logic link_clk;
  assign link_clk = USE_USER_CLOCK ? readback_shift_clock : config_clock; // R16 R17

  typedef struct packed {
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic ack_tog;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic done_meta;
    logic done_sync;
    logic [FRAME_BITS-1:0] word_out;
    logic [FRAMES-1:0][CAP_W-1:0] cap;
    logic [FRAMES-1:0][FRAME_BITS-1:0] mem;
  } cmr_core_t;

  typedef struct packed {
    logic ce_meta;
    logic ce_sync;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic done_meta;
    logic done_sync;
    logic ack_meta;
    logic ack_sync;
    logic ack_seen;
    cmr_state_t state;
    logic [CW-1:0] cnt;
    logic [FW-1:0] frame;
    logic req_tog;
    logic [FW-1:0] req_frame;
    logic [FRAME_BITS-1:0] next_word;
    logic [FRAME_BITS-1:0] shift_word;
    logic [CRC_W-1:0] crc;
    logic rip;
    logic dout;
  } cmr_link_t;

  cmr_core_t core_reg;
  cmr_core_t core_next;
  cmr_link_t link_reg;
  cmr_link_t link_next;

  // ---------------- system clock side: memory image, capture, frame fetch
  always_comb begin
    logic [FRAME_BITS-1:0] row;
    row = '0;
    core_next = core_reg;
    core_next.req_meta = link_reg.req_tog;
    core_next.req_sync = core_reg.req_meta;
    core_next.trig_meta = readback_trigger;
    core_next.trig_sync = core_reg.trig_meta;
    core_next.done_meta = config_done;
    core_next.done_sync = core_reg.done_meta;
    if (ce) begin
      core_next.trig_prev = core_reg.trig_sync;
      // loaded bits are stored as written and read back uninverted, except at the capture and forced-high positions
      if (cfg_wr_en) begin
        core_next.mem[cfg_wr_frame] = cfg_wr_data; // R10
      end else if (ram_wr_en) begin
        core_next.mem[ram_wr_frame][ram_wr_bit] = ram_wr_value; // R13
      end
      if (CAPTURE_EN && core_reg.done_sync && core_reg.trig_sync && !core_reg.trig_prev) begin
        for (int f = 0; f < FRAMES; f++) begin
          core_next.cap[f] = ~capture_nodes[f*CAP_W +: CAP_W]; // R11
        end
      end
      // req_frame is stable for the whole handshake, so sampling it here is safe
      if (core_reg.req_sync != core_reg.req_seen) begin
        row = core_reg.mem[link_reg.req_frame];
        if (CAPTURE_EN) begin
          row[CAP_POS +: CAP_W] = core_reg.cap[link_reg.req_frame]; // R11
        end
        // without capture the configured bits stay in place
        core_next.word_out = row; // R12 R13
        core_next.ack_tog = ~core_reg.ack_tog;
        core_next.req_seen = core_reg.req_sync;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // ---------------- link side: stream sequencer on the selected readback clock
  always_comb begin
    logic bit_out;
    logic trig_rise;
    logic trig_fall;
    bit_out = FILL_LEVEL;
    link_next = link_reg;
    link_next.ce_meta = ce;
    link_next.ce_sync = link_reg.ce_meta;
    link_next.trig_meta = readback_trigger;
    link_next.trig_sync = link_reg.trig_meta;
    link_next.done_meta = config_done;
    link_next.done_sync = link_reg.done_meta;
    link_next.ack_meta = core_reg.ack_tog;
    link_next.ack_sync = link_reg.ack_meta;
    trig_rise = link_reg.trig_sync && !link_reg.trig_prev;
    trig_fall = !link_reg.trig_sync && link_reg.trig_prev;
    if (link_reg.ce_sync) begin
      link_next.trig_prev = link_reg.trig_sync;
      // the fetched word is held by the core side until the next request
      if (link_reg.ack_sync != link_reg.ack_seen) begin
        link_next.next_word = core_reg.word_out; // R18
        link_next.ack_seen = link_reg.ack_sync;
      end
      unique case (link_reg.state)
        CMR_IDLE: begin
          link_next.rip = 1'b0;
          link_next.dout = IDLE_LEVEL;
          // an unconnected trigger never rises, so no stream ever starts
          if (trig_rise && link_reg.done_sync) begin // R2 R21 R23
            link_next.rip = 1'b1; // R2
            link_next.state = CMR_DUMMY;
            link_next.cnt = '0;
            link_next.frame = '0;
            link_next.crc = CRC_INIT;
            // the dummies plus the first start bit are the first load window
            link_next.req_frame = '0; // R18
            link_next.req_tog = ~link_reg.req_tog; // R18
          end
        end
        CMR_DUMMY: begin
          // stream opens on dummies, never on a preamble
          link_next.dout = FILL_LEVEL; // R4 R5
          link_next.cnt = link_reg.cnt + 1'b1;
          if (link_reg.cnt == DUMMY_LAST) begin
            link_next.state = CMR_START; // R5
          end
        end
        CMR_START: begin
          link_next.dout = START_LEVEL; // R5 R3
          link_next.shift_word = link_reg.next_word; // R18
          link_next.crc = cmr_crc_step(link_reg.crc, START_LEVEL, CRC_POLY);
          link_next.cnt = '0;
          link_next.state = CMR_DATA;
        end
        CMR_DATA: begin
          bit_out = link_reg.shift_word[0]; // R10
          if (link_reg.frame == '0 && link_reg.cnt < FIRST_HIGH_END) begin
            bit_out = FILL_LEVEL; // R6
          end
          if (link_reg.frame == LAST_FRAME && link_reg.cnt >= LAST_HIGH_START) begin
            bit_out = FILL_LEVEL; // R8
          end
          link_next.dout = bit_out; // R3
          link_next.crc = cmr_crc_step(link_reg.crc, bit_out, CRC_POLY);
          link_next.shift_word = {1'b0, link_reg.shift_word[FRAME_BITS-1:1]};
          if (link_reg.cnt == REQ_POS && link_reg.frame != LAST_FRAME) begin
            link_next.req_frame = link_reg.frame + 1'b1; // R18
            link_next.req_tog = ~link_reg.req_tog; // R18
          end
          if (link_reg.cnt == DATA_LAST) begin
            link_next.state = CMR_CHECK;
            link_next.cnt = '0;
          end else begin
            link_next.cnt = link_reg.cnt + 1'b1;
          end
        end
        CMR_CHECK: begin
          link_next.dout = FILL_LEVEL; // R7
          link_next.crc = cmr_crc_step(link_reg.crc, FILL_LEVEL, CRC_POLY);
          // request position is always the last data bit, so this check-bit branch never fires
          if (CW'(FRAME_BITS) + link_reg.cnt == REQ_POS && link_reg.frame != LAST_FRAME) begin
            link_next.req_frame = link_reg.frame + 1'b1; // R18
            link_next.req_tog = ~link_reg.req_tog; // R18
          end
          if (link_reg.cnt == CHECK_LAST) begin // R7
            link_next.cnt = '0;
            if (link_reg.frame == LAST_FRAME) begin
              link_next.state = CMR_LSTART; // R9
            end else begin
              link_next.frame = link_reg.frame + 1'b1;
              link_next.state = CMR_START;
            end
          end else begin
            link_next.cnt = link_reg.cnt + 1'b1;
          end
        end
        CMR_LSTART: begin
          // signature covers everything from the first start bit to the last check bit; this final start bit is left out
          link_next.dout = START_LEVEL; // R9
          link_next.cnt = '0;
          link_next.state = CMR_CRC;
        end
        CMR_CRC: begin
          link_next.dout = link_reg.crc[CRC_W-1]; // R9
          link_next.crc = {link_reg.crc[CRC_W-2:0], 1'b0};
          link_next.cnt = link_reg.cnt + 1'b1;
          if (link_reg.cnt == CRC_LAST) begin
            link_next.state = CMR_END;
          end
        end
        CMR_END: begin
          // unless aborted, in-progress only drops after the last signature bit was presented
          link_next.rip = 1'b0; // R9
          link_next.dout = IDLE_LEVEL;
          link_next.state = CMR_IDLE;
        end
      endcase
      // an outstanding fetch is simply dropped; its late ack only refreshes next_word
      if (ABORT_EN && link_reg.state != CMR_IDLE && trig_fall) begin // R14 R17
        link_next.state = CMR_IDLE; // R14
        link_next.rip = 1'b0; // R14
        link_next.dout = IDLE_LEVEL;
        link_next.cnt = '0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin // R16
    if (!reset_n) begin
      link_reg <= '0;
      link_reg.state <= CMR_IDLE;
      link_reg.dout <= IDLE_LEVEL;
      link_reg.crc <= CRC_INIT;
    end else begin
      link_reg <= link_next; // R1
    end
  end

  assign read_in_progress = link_reg.rip;
  assign readback_serial_out = link_reg.dout;

endmodule
`default_nettype wire

/* File: tb/cmr_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmr_sva #(
  parameter int FRAMES = 8,
  parameter int FRAME_BITS = 32
) (
  input wire logic config_clock,
  input wire logic reset_n,
  input wire logic config_done,
  input wire logic readback_trigger,
  input wire logic read_in_progress,
  input wire logic readback_serial_out
);
  localparam int P = FRAME_BITS + 5;
  localparam int E = 6 + FRAMES * P;
  logic [15:0] cnt_reg;
  wire logic rip = read_in_progress;
  wire logic dout = readback_serial_out;
  // cnt_reg counts edges since in-progress rose: the rise bit is 0, the dummies 1 to 5, the first start bit 6
  wire logic in_frm = rip && cnt_reg >= 16'h6 && cnt_reg < E;
  wire logic [15:0] pos = 16'((cnt_reg - 16'h6) % P);
  always_ff @(posedge config_clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0;
    end else begin
      cnt_reg <= rip ? cnt_reg + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge config_clock); endclocking
  default disable iff (!reset_n);
  AST_DUMMIES: assert property ($rose(rip) |-> dout [*6] ##1 !dout)
    else $error("dummy bits or first start wrong");
  AST_FIRST_DATA: assert property ($rose(rip) |-> ##7 dout [*2])
    else $error("first data bits not high");
  AST_TRIG_START: assert property ($rose(rip) |->
    $past(readback_trigger, 3) && !$past(readback_trigger, 4) && config_done)
    else $error("readback began without trigger rise");
  AST_NO_RESTART: assert property ($fell(rip) && readback_trigger |=> !rip [*8])
    else $error("readback restarted with trigger held");
  AST_ABORT: assert property ($fell(readback_trigger) && rip |-> ##[1:4] !rip)
    else $error("abort did not end readback");
  AST_LENGTH: assert property ($fell(rip) && $past(readback_trigger) |-> cnt_reg == E + 12)
    else $error("readback length wrong");
  AST_CHECK_HIGH: assert property (in_frm && pos > FRAME_BITS |-> dout)
    else $error("check bit low");
  AST_LAST_SEVEN: assert property (rip && cnt_reg >= E - 7 && cnt_reg < E |-> dout)
    else $error("last frame tail low");
  AST_START_LOW: assert property (in_frm && pos == 16'h0 |-> !dout)
    else $error("frame start bit high");
  AST_FINAL_START: assert property (rip && cnt_reg == E |-> !dout)
    else $error("final start bit high");
endmodule
bind cmr_config_memory_readback cmr_sva #(.FRAMES(FRAMES), .FRAME_BITS(FRAME_BITS)) i_cmr_sva (
  .config_clock, .reset_n, .config_done, .readback_trigger, .read_in_progress, .readback_serial_out);
`default_nettype wire

/* File: tb/cmr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmr_ctrl_model (
  input wire logic run,
  input wire logic go,
  input wire logic config_done,
  input wire logic read_in_progress,
  input wire logic readback_serial_out,
  output logic link_clk,
  output logic readback_trigger,
  output logic [63:0] seen,
  output logic [15:0] n_seen
);
  logic was_reg;
  logic [1:0] dn_reg;
  initial begin
    readback_trigger = 1'b0;
    seen = 64'h0;
    n_seen = 16'h0;
    was_reg = 1'b0;
    dn_reg = 2'h0;
  end
  // never paused while run is high, so load windows and re-arm clocks are always given
  initial begin
    link_clk = 1'b0;
    #3;
    forever begin
      #16;
      link_clk = run & ~link_clk;
    end
  end
  always @(negedge link_clk) begin
    dn_reg <= !config_done ? 2'h0 : (dn_reg == 2'h3 ? dn_reg : dn_reg + 2'h1);
    readback_trigger <= go && (!config_done || dn_reg == 2'h3);
    if (was_reg && read_in_progress) begin
      seen[n_seen] <= readback_serial_out;
      n_seen <= n_seen + 16'h1;
    end
    if (!was_reg && read_in_progress) begin
      n_seen <= 16'h0;
    end
    was_reg <= read_in_progress;
  end
endmodule
`default_nettype wire

/* File: tb/cmr_config_memory_readback_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cmr_config_memory_readback_tb;
  logic clk, reset_n, ce, config_done, cfg_wr_en, cfg_wr_frame, ram_wr_en, ram_wr_frame, ram_wr_value;
  logic run, go, lclk, trig, rip, dout;
  logic [15:0] cfg_wr_data, capture_nodes, n_seen;
  logic [3:0] ram_wr_bit;
  logic [63:0] seen;
  logic [15:0] row [2];
  int fails = 0;
  int n_checks = 0;
  cmr_config_memory_readback #(.FRAMES(2), .FRAME_BITS(16)) i_cmr_config_memory_readback (
    .clk(clk), .reset_n(reset_n), .ce(ce), .config_clock(lclk), .readback_shift_clock(1'b0),
    .config_done(config_done), .readback_trigger(trig), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_frame(cfg_wr_frame), .cfg_wr_data(cfg_wr_data), .ram_wr_en(ram_wr_en),
    .ram_wr_frame(ram_wr_frame), .ram_wr_bit(ram_wr_bit), .ram_wr_value(ram_wr_value),
    .capture_nodes(capture_nodes), .read_in_progress(rip), .readback_serial_out(dout));
  cmr_ctrl_model i_cmr_ctrl_model (.run(run), .go(go), .config_done(config_done),
    .read_in_progress(rip), .readback_serial_out(dout), .link_clk(lclk),
    .readback_trigger(trig), .seen(seen), .n_seen(n_seen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic lk(int n);
    repeat (n) @(negedge lclk);
  endtask
  task automatic wr_row(logic f, logic [15:0] d);
    @(negedge clk);
    cfg_wr_en = 1'b1;
    cfg_wr_frame = f;
    cfg_wr_data = d;
    row[f] = d;
    @(negedge clk);
    cfg_wr_en = 1'b0;
  endtask
  // the signature is worked out here bit by bit, independent of the design
  task automatic exp_stream(output logic [63:0] ex);
    logic [15:0] d;
    logic [10:0] c;
    logic b;
    int k;
    c = 11'h7ff;
    ex = 64'h1f;
    k = 5;
    for (int f = 0; f < 2; f++) begin
      d = row[f];
      d[8 +: 8] = ~capture_nodes[f * 8 +: 8];
      if (f == 0) d[1:0] = 2'h3;
      if (f == 1) d[15:13] = 3'h7;
      for (int i = 0; i < 21; i++) begin
        b = (i == 0) ? 1'b0 : (i < 17 ? d[i - 1] : 1'b1);
        ex[k] = b;
        k++;
        c = {c[9:0], 1'b0} ^ ((c[10] ^ b) ? 11'h305 : 11'h0);
      end
    end
    ex[k] = 1'b0;
    for (int i = 10; i >= 0; i--) ex[k + 11 - i] = c[i];
  endtask
  task automatic do_read();
    logic [63:0] ex;
    int t;
    exp_stream(ex);
    go = 1'b1;
    t = 0;
    while (rip !== 1'b1 && t < 20) begin
      @(negedge lclk);
      t++;
    end
    chk("rip rise", 16'h1, {15'h0, rip});
    while (rip === 1'b1 && t < 200) begin
      @(negedge lclk);
      t++;
    end
    chk("bit count", 16'h3b, n_seen);
    for (int i = 0; i < 59; i++) chk("stream bit", {15'h0, ex[i]}, {15'h0, seen[i]});
    lk(12);
    chk("rip with trigger held", 16'h0, {15'h0, rip});
    go = 1'b0;
    lk(6);
  endtask
  task automatic t_refuse();
    go = 1'b1;
    lk(12);
    chk("rip without done", 16'h0, {15'h0, rip});
    go = 1'b0;
    lk(6);
  endtask
  task automatic t_abort();
    go = 1'b1;
    lk(30);
    go = 1'b0;
    lk(6);
    chk("rip after abort", 16'h0, {15'h0, rip});
    chk("dout after abort", 16'h1, {15'h0, dout});
    lk(4);
    do_read();
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    config_done = 1'b0;
    {cfg_wr_en, cfg_wr_frame, ram_wr_en, ram_wr_frame, ram_wr_value} = 5'h0;
    cfg_wr_data = 16'h0;
    ram_wr_bit = 4'h0;
    capture_nodes = 16'hc36a;
    run = 1'b1;
    go = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    wr_row(1'b0, 16'h5a3c);
    wr_row(1'b1, 16'h96e1);
    @(negedge clk);
    ram_wr_en = 1'b1;
    ram_wr_frame = 1'b1;
    ram_wr_bit = 4'h4;
    ram_wr_value = ~row[1][4];
    row[1][4] = ~row[1][4];
    @(negedge clk);
    ram_wr_en = 1'b0;
    t_refuse();
    @(negedge clk);
    config_done = 1'b1;
    lk(6);
    do_read();
    t_abort();
    report_and_stop();
  end
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
